/* rtl/hce_top.sv */
// hold compare outputs, terminal queries and error replies
`timescale 1ns/1ns
// Notes on behaviour
// - peak hold query replies on or off, valid when multipoint hold is off
// - malformed or undefined command gives a dedicated error reply only
// - corrupt condition data reported until condition data reset
// - corrupt comparison data reply carries the broken pattern number
// - corrupt calibration data reported until calibration reset
// - corrupt zero data reported until a zero refresh
// - other abnormality reported with code, cleared only by power cycle
// - two point: above or below set when a trigger finds value out of limits
// - one point: within set when second trigger finds value within limits
// - two point: within only after both triggers found values within
// - two point: within never set when second trigger precedes the first
// - one point: within held while value stays within after second trigger
// - free run: display value frozen while freeze input asserted
// - free run: comparison outputs and display off while reset input high
// - reset terminal query replies on or off per the terminal
module hce_top
  import hce_pkg::*;
#(
  parameter int VAL_W = hce_pkg::HCE_VAL_W
) (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // mode and measurement
  input  wire hce_pkg::hce_mode_t             mode,
  input  wire logic [VAL_W-1:0]               live_value,
  input  wire logic                           value_above,
  input  wire logic                           value_below,
  // terminal pins
  input  wire logic                           first_hold_trigger,
  input  wire logic                           second_hold_trigger,
  input  wire logic                           display_freeze_input,
  input  wire logic                           comparison_reset_input,
  input  wire logic                           peak_hold_input,
  // command from the link parser
  input  wire logic                           cmd_valid,
  input  wire logic [2:0]                     cmd_code,
  input  wire logic                           cmd_malformed,
  // memory fault reports
  input  wire logic                           fault_cond,
  input  wire logic                           fault_comp,
  input  wire logic [hce_pkg::HCE_PAT_W-1:0]  fault_comp_pattern,
  input  wire logic                           fault_cal,
  input  wire logic                           fault_zero,
  input  wire logic                           fault_other,
  input  wire logic [hce_pkg::HCE_CODE_W-1:0] fault_other_code,
  // recovery actions
  input  wire logic                           cond_defaults_done,
  input  wire logic                           comp_defaults_done,
  input  wire logic                           cal_defaults_done,
  input  wire logic                           zero_refresh_done,
  // reply
  output logic                                rsp_valid,
  output hce_pkg::hce_rsp_t                   rsp_code,
  output logic [hce_pkg::HCE_CODE_W-1:0]      rsp_arg,
  // comparison outputs
  output logic                                within_limits_output,
  output logic                                above_limit_output,
  output logic                                below_limit_output,
  output logic [VAL_W-1:0]                    display_value,
  output logic                                display_on
);
  import hce_pkg::*;

  // refuse a display width that the registers cannot hold
  if (VAL_W < 1) begin : g_bad_width
    $error("VAL_W must be positive");
  end

  // ==========================================================
  // pin synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       trig1_d;
  logic       trig2_d;
  logic       trig1;
  logic       trig2;
  logic       freeze;
  logic       cmp_rst;
  logic       peak_pin;

  // pins are asynchronous; only the second flop feeds any logic
  // two flops per pin, then edge history
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a  <= 5'h00;
      sync_b  <= 5'h00;
      trig1_d <= 1'b0;
      trig2_d <= 1'b0;
    end else begin
      sync_a  <= {peak_hold_input, comparison_reset_input,
                  display_freeze_input, second_hold_trigger,
                  first_hold_trigger};
      sync_b  <= sync_a;
      trig1_d <= sync_b[0];
      trig2_d <= sync_b[1];
    end
  end

  assign trig1    = sync_b[0] & ~trig1_d;
  assign trig2    = sync_b[1] & ~trig2_d;
  assign freeze   = sync_b[2];
  assign cmp_rst  = sync_b[3];
  assign peak_pin = sync_b[4];

  // ==========================================================
  // sticky fault flags
  logic                  err_cond;
  logic                  err_comp;
  logic                  err_cal;
  logic                  err_zero;
  logic                  err_other;
  logic [HCE_PAT_W-1:0]  comp_pat;
  logic [HCE_CODE_W-1:0] other_code;
  logic                  next_err_cond;
  logic                  next_err_comp;
  logic                  next_err_cal;
  logic                  next_err_zero;
  logic                  next_err_other;
  logic [HCE_PAT_W-1:0]  next_comp_pat;
  logic [HCE_CODE_W-1:0] next_other_code;

  // fault set wins over a recovery in the same cycle
  // the other code keeps the first fault, so later ones cannot mask it
  always_comb begin
    next_err_cond   = fault_cond | (err_cond & ~cond_defaults_done);
    next_err_comp   = fault_comp | (err_comp & ~comp_defaults_done);
    next_err_cal    = fault_cal | (err_cal & ~cal_defaults_done);
    next_err_zero   = fault_zero | (err_zero & ~zero_refresh_done);
    next_err_other  = fault_other | err_other;
    next_comp_pat   = fault_comp ? fault_comp_pattern : comp_pat;
    next_other_code = (fault_other & ~err_other) ? fault_other_code
                                                 : other_code;
  end

  // fault flag registers; only reset models the power cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_cond   <= 1'b0;
      err_comp   <= 1'b0;
      err_cal    <= 1'b0;
      err_zero   <= 1'b0;
      err_other  <= 1'b0;
      comp_pat   <= '0;
      other_code <= '0;
    end else begin
      err_cond   <= next_err_cond;
      err_comp   <= next_err_comp;
      err_cal    <= next_err_cal;
      err_zero   <= next_err_zero;
      err_other  <= next_err_other;
      comp_pat   <= next_comp_pat;
      other_code <= next_other_code;
    end
  end

  // ==========================================================
  // command replies
  hce_rsp_t              next_rsp_code;
  logic [HCE_CODE_W-1:0] next_rsp_arg;
  logic                  next_rsp_valid;

  // faults first, then format errors, then queries
  // a fault blocks every command until its recovery arrives; the other fault blocks them until reset
  always_comb begin
    next_rsp_valid = cmd_valid;
    next_rsp_code  = HCE_RSP_NONE;
    next_rsp_arg   = '0;
    if (cmd_valid) begin
      if (err_other) begin
        next_rsp_code = HCE_RSP_ERR_OTHER;
        next_rsp_arg  = other_code;
      end else if (err_cond) begin
        next_rsp_code = HCE_RSP_ERR_COND;
      end else if (err_comp) begin
        next_rsp_code = HCE_RSP_ERR_COMP;
        next_rsp_arg  = {{(HCE_CODE_W-HCE_PAT_W){1'b0}}, comp_pat};
      end else if (err_cal) begin
        next_rsp_code = HCE_RSP_ERR_CAL;
      end else if (err_zero) begin
        next_rsp_code = HCE_RSP_ERR_ZERO;
      end else if (cmd_malformed) begin
        next_rsp_code = HCE_RSP_ERR_FMT;
      end else if (cmd_code == HCE_CMD_PEAK_QUERY) begin
        next_rsp_code = peak_pin ? HCE_RSP_PEAK_ON : HCE_RSP_PEAK_OFF;
      end else if (cmd_code == HCE_CMD_RST_QUERY) begin
        next_rsp_code = cmp_rst ? HCE_RSP_RST_ON : HCE_RSP_RST_OFF;
      end else begin
        next_rsp_code = HCE_RSP_ERR_FMT;
      end
    end
  end

  // reply registers; replies touch nothing else
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_code  <= HCE_RSP_NONE;
      rsp_arg   <= '0;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp_code  <= next_rsp_code;
      rsp_arg   <= next_rsp_arg;
    end
  end

  // ==========================================================
  // comparison outputs
  // seq remembers whether the first trigger found the value within
  hce_seq_t   seq;
  hce_seq_t   next_seq;
  logic       next_within;
  logic       next_above;
  logic       next_below;
  logic       next_disp_on;
  logic [VAL_W-1:0] next_disp;
  logic       in_lim;

  // within when neither limit is crossed
  assign in_lim = ~value_above & ~value_below;

  // per mode output decisions
  always_comb begin
    next_seq     = seq;
    next_within  = within_limits_output;
    next_above   = above_limit_output;
    next_below   = below_limit_output;
    next_disp_on = 1'b1;
    next_disp    = live_value;
    unique case (mode)
      // one point: the second trigger takes the sample
      HCE_MODE_ONE: begin
        next_seq = HCE_SEQ_IDLE;
        if (trig2) begin
          next_within = in_lim;
          next_above  = value_above;
          next_below  = value_below;
        end else if (within_limits_output) begin
          next_within = in_lim;
        end
      end
      // two point: first trigger arms, second trigger decides
      HCE_MODE_TWO: begin
        if (trig1) begin
          next_seq    = in_lim ? HCE_SEQ_FIRST : HCE_SEQ_DONE;
          next_within = 1'b0;
          next_above  = value_above;
          next_below  = value_below;
        end else if (trig2) begin
          next_seq = HCE_SEQ_IDLE;
          if (value_above | value_below) begin
            next_within = 1'b0;
            next_above  = above_limit_output | value_above;
            next_below  = below_limit_output | value_below;
          end else begin
            next_within = (seq == HCE_SEQ_FIRST);
          end
        end
      end
      // free run; the unused mode code behaves the same
      default: begin
        next_seq    = HCE_SEQ_IDLE;
        next_within = in_lim;
        next_above  = value_above;
        next_below  = value_below;
        if (freeze) begin
          next_disp = display_value;
        end
        if (cmp_rst) begin
          next_within  = 1'b0;
          next_above   = 1'b0;
          next_below   = 1'b0;
          next_disp_on = 1'b0;
        end
      end
    endcase
  end

  // comparison registers
  // outputs stay low through reset so the field sees no false result
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq                  <= HCE_SEQ_IDLE;
      within_limits_output <= 1'b0;
      above_limit_output   <= 1'b0;
      below_limit_output   <= 1'b0;
      display_value        <= '0;
      display_on           <= 1'b0;
    end else begin
      seq                  <= next_seq;
      within_limits_output <= next_within;
      above_limit_output   <= next_above;
      below_limit_output   <= next_below;
      display_value        <= next_disp;
      display_on           <= next_disp_on;
    end
  end

endmodule : hce_top

/* rtl/hce_pkg.sv */
// package of constants and types for the hold compare and error reply block
package hce_pkg;
  // ==========================================================
  // reply codes
  typedef enum logic [3:0] {
    HCE_RSP_NONE      = 4'h0,
    HCE_RSP_PEAK_ON   = 4'h1,
    HCE_RSP_PEAK_OFF  = 4'h2,
    HCE_RSP_RST_ON    = 4'h3,
    HCE_RSP_RST_OFF   = 4'h4,
    HCE_RSP_ERR_FMT   = 4'h5,
    HCE_RSP_ERR_COND  = 4'h6,
    HCE_RSP_ERR_COMP  = 4'h7,
    HCE_RSP_ERR_CAL   = 4'h8,
    HCE_RSP_ERR_ZERO  = 4'h9,
    HCE_RSP_ERR_OTHER = 4'hA
  } hce_rsp_t;
  // ==========================================================
  // command codes
  typedef enum logic [2:0] {
    HCE_CMD_PEAK_QUERY = 3'h1,
    HCE_CMD_RST_QUERY  = 3'h2
  } hce_cmd_t;
  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    HCE_MODE_FREE = 2'h0,
    HCE_MODE_ONE  = 2'h1,
    HCE_MODE_TWO  = 2'h2
  } hce_mode_t;
  // ==========================================================
  // two point sequence states
  typedef enum logic [1:0] {
    HCE_SEQ_IDLE  = 2'h0,
    HCE_SEQ_FIRST = 2'h1,
    HCE_SEQ_DONE  = 2'h2
  } hce_seq_t;
  localparam int HCE_PAT_W = 4;
  localparam int HCE_VAL_W = 16;
  localparam int HCE_CODE_W = 8;
endpackage : hce_pkg

/* tb/hce_host.sv */
// host model that issues one text command per request
`timescale 1ns/1ns
module hce_host (
  // clock
  input  wire logic       clk_sys,
  // request from the bench
  input  wire logic       send,
  input  wire logic [2:0] code,
  input  wire logic       bad,
  // command to the block
  output logic            cmd_valid,
  output logic [2:0]      cmd_code,
  output logic            cmd_malformed
);
  // ==========================================================
  // command launch
  // a command stands one cycle; idle code is scrambled, never held
  always_ff @(posedge clk_sys) begin
    cmd_valid     <= send;
    cmd_code      <= send ? code : ~code;
    cmd_malformed <= send & bad;
  end
endmodule : hce_host

/* tb/hce_top_asserts.sv */
// checker of replies and comparison outputs
`timescale 1ns/1ns
module hce_top_asserts #(
  parameter int VAL_W = 16
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // inputs watched
  input wire hce_pkg::hce_mode_t mode,
  input wire logic              value_above,
  input wire logic              value_below,
  input wire logic              display_freeze_input,
  input wire logic              comparison_reset_input,
  input wire logic              cmd_valid,
  input wire logic [2:0]        cmd_code,
  input wire logic              cmd_malformed,
  // outputs watched
  input wire logic              rsp_valid,
  input wire hce_pkg::hce_rsp_t rsp_code,
  input wire logic              within_limits_output,
  input wire logic              above_limit_output,
  input wire logic              below_limit_output,
  input wire logic [VAL_W-1:0]  display_value,
  input wire logic              display_on
);
  import hce_pkg::*;
  logic other_seen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // helper
  // remembers a reported fault that only reset clears
  always_ff @(posedge clk_sys) begin
    if (rst) other_seen <= 1'b0;
    else if (rsp_valid && rsp_code == HCE_RSP_ERR_OTHER) other_seen <= 1'b1;
  end
  // pin levels held long enough to pass the synchronisers
  sequence s_frozen;
    (mode == HCE_MODE_FREE && display_freeze_input) [*5];
  endsequence
  sequence s_blanked;
    (mode == HCE_MODE_FREE && comparison_reset_input) [*5];
  endsequence
  // ==========================================================
  // assertions
  chk_cmd_reply: assert property (cmd_valid |=> rsp_valid)
    else $error("no reply after command");
  chk_no_stray: assert property (!cmd_valid |=> !rsp_valid)
    else $error("reply without command");
  chk_bad_fmt: assert property (
    cmd_valid && cmd_malformed |=> rsp_code >= HCE_RSP_ERR_FMT)
    else $error("malformed command answered");
  chk_undef_cmd: assert property (
    cmd_valid && !(cmd_code inside {3'h1, 3'h2})
    |=> rsp_code >= HCE_RSP_ERR_FMT) else $error("undefined command answered");
  chk_other_stays: assert property (
    rsp_valid && other_seen |-> rsp_code == HCE_RSP_ERR_OTHER)
    else $error("fault reply cleared without reset");
  chk_freeze_hold: assert property (
    s_frozen |=> $stable(display_value)) else $error("display moved");
  chk_reset_blank: assert property (s_blanked |-> !display_on &&
    !within_limits_output && !above_limit_output && !below_limit_output)
    else $error("outputs not blanked");
  chk_one_drop: assert property (
    mode == HCE_MODE_ONE && (value_above || value_below)
    |-> ##[1:2] !within_limits_output) else $error("within kept");
endmodule : hce_top_asserts
bind hce_top hce_top_asserts #(.VAL_W(VAL_W)) u_chk (.*);

/* tb/hce_top_tb_top.sv */
// self-checking bench of the hold compare and reply block
`timescale 1ns/1ns
module hce_top_tb_top;
  import hce_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, va = 1'b0, vb = 1'b0, frz = 1'b0;
  logic crst = 1'b0, pk = 1'b0, send = 1'b0, bad = 1'b0, cv, cm, rv;
  logic wl, al, bl, don;
  logic [2:0] code = 3'h0, cc;
  logic [1:0] trg = 2'h0;
  logic [4:0] flt = 5'h00;
  logic [3:0] clr = 4'h0;
  logic [15:0] lv = 16'h0000, dv;
  logic [7:0] ra;
  logic [3:0] pat = 4'h9;
  logic [7:0] ocd = 8'h5A;
  hce_mode_t mode = HCE_MODE_FREE;
  hce_rsp_t rc;
  int fail_count = 0, n_tests = 0, cyc = 0;
  // ==========================================================
  // clock, timeout and instances
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  hce_host u_hce_host (.clk_sys(clk_sys), .send(send), .code(code),
    .bad(bad), .cmd_valid(cv), .cmd_code(cc), .cmd_malformed(cm));
  hce_top u_hce_top (.clk_sys(clk_sys), .rst(rst), .mode(mode),
    .live_value(lv), .value_above(va), .value_below(vb),
    .first_hold_trigger(trg[0]), .second_hold_trigger(trg[1]),
    .display_freeze_input(frz), .comparison_reset_input(crst),
    .peak_hold_input(pk), .cmd_valid(cv), .cmd_code(cc),
    .cmd_malformed(cm), .fault_cond(flt[0]), .fault_comp(flt[1]),
    .fault_comp_pattern(pat), .fault_cal(flt[2]), .fault_zero(flt[3]),
    .fault_other(flt[4]), .fault_other_code(ocd),
    .cond_defaults_done(clr[0]), .comp_defaults_done(clr[1]),
    .cal_defaults_done(clr[2]), .zero_refresh_done(clr[3]),
    .rsp_valid(rv), .rsp_code(rc), .rsp_arg(ra),
    .within_limits_output(wl), .above_limit_output(al),
    .below_limit_output(bl), .display_value(dv), .display_on(don));
  // ==========================================================
  // shared tasks
  task wt(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task ck(string n, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  // sends one command and judges the reply pulse
  task ask(logic [2:0] c, logic b, hce_rsp_t e, logic [7:0] a);
    @(posedge clk_sys) send <= 1'b1;
    code <= c;
    bad <= b;
    @(posedge clk_sys) send <= 1'b0;
    wt(1);
    ck("rsp_valid", 1'b1, rv);
    ck("rsp_code", e, rc);
    ck("rsp_arg", a, ra);
  endtask : ask
  // trigger held four cycles so the synchroniser sees it
  task trig(int k);
    @(posedge clk_sys) trg[k] <= 1'b1;
    wt(3);
    @(posedge clk_sys) trg[k] <= 1'b0;
    wt(6);
  endtask : trig
  // ==========================================================
  // scenarios
  task t_query();
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_sys) pk <= i[0];
      @(posedge clk_sys) crst <= i[0];
      wt(6);
      ask(3'h1, 1'b0, i ? HCE_RSP_PEAK_ON : HCE_RSP_PEAK_OFF, 8'h00);
      ask(3'h2, 1'b0, i ? HCE_RSP_RST_ON : HCE_RSP_RST_OFF, 8'h00);
    end
  endtask : t_query
  task t_faults();
    hce_rsp_t ec [4];
    ec = '{HCE_RSP_ERR_COND, HCE_RSP_ERR_COMP, HCE_RSP_ERR_CAL,
           HCE_RSP_ERR_ZERO};
    for (int k = 0; k < 4; k++) begin
      // fault and recovery in one cycle: the fault must win
      @(posedge clk_sys) flt[k] <= 1'b1;
      clr[k] <= 1'b1;
      pat <= 4'h9;
      @(posedge clk_sys) flt[k] <= 1'b0;
      clr[k] <= 1'b0;
      pat <= 4'h3;
      for (int j = 0; j < 2; j++) begin
        ask(3'h1, 1'b0, ec[k], (k == 1) ? 8'h09 : 8'h00);
      end
      @(posedge clk_sys) clr[k] <= 1'b1;
      @(posedge clk_sys) clr[k] <= 1'b0;
      ask(3'h1, 1'b0, HCE_RSP_PEAK_OFF, 8'h00);
    end
  endtask : t_faults
  task t_one();
    @(posedge clk_sys) mode <= HCE_MODE_ONE;
    @(posedge clk_sys) va <= 1'b1;
    wt(3);
    @(posedge clk_sys) va <= 1'b0;
    wt(3);
    ck("within", 1'b0, wl);
    trig(1);
    ck("within", 1'b1, wl);
    @(posedge clk_sys) va <= 1'b1;
    wt(3);
    ck("within", 1'b0, wl);
    @(posedge clk_sys) va <= 1'b0;
    trig(1);
    ck("within", 1'b1, wl);
    ask(3'h1, 1'b1, HCE_RSP_ERR_FMT, 8'h00);
    ask(3'h5, 1'b0, HCE_RSP_ERR_FMT, 8'h00);
    ck("within", 1'b1, wl);
  endtask : t_one
  task t_two();
    @(posedge clk_sys) mode <= HCE_MODE_TWO;
    @(posedge clk_sys) vb <= 1'b1;
    trig(0);
    ck("below", 1'b1, bl);
    @(posedge clk_sys) vb <= 1'b0;
    trig(1);
    ck("within", 1'b0, wl);
    trig(0);
    trig(1);
    ck("within", 1'b1, wl);
    trig(1);
    ck("within", 1'b0, wl);
    @(posedge clk_sys) va <= 1'b1;
    trig(1);
    ck("above", 1'b1, al);
  endtask : t_two
  task t_free();
    @(posedge clk_sys) mode <= HCE_MODE_FREE;
    @(posedge clk_sys) lv <= 16'h1234;
    wt(4);
    @(posedge clk_sys) frz <= 1'b1;
    wt(4);
    @(posedge clk_sys) lv <= 16'h5678;
    wt(4);
    ck("display", 16'h1234, dv);
    @(posedge clk_sys) frz <= 1'b0;
    @(posedge clk_sys) va <= 1'b1;
    wt(4);
    ck("display", 16'h5678, dv);
    @(posedge clk_sys) crst <= 1'b1;
    wt(6);
    ck("above", 1'b0, al);
    ck("display_on", 1'b0, don);
    @(posedge clk_sys) crst <= 1'b0;
    wt(6);
    ck("above", 1'b1, al);
  endtask : t_free
  task t_other();
    @(posedge clk_sys) flt[4] <= 1'b1;
    @(posedge clk_sys) flt[4] <= 1'b0;
    ocd <= 8'hC3;
    ask(3'h1, 1'b0, HCE_RSP_ERR_OTHER, 8'h5A);
    @(posedge clk_sys) clr <= 4'hF;
    @(posedge clk_sys) clr <= 4'h0;
    ask(3'h2, 1'b0, HCE_RSP_ERR_OTHER, 8'h5A);
    // a reset in mid run stands for the power cycle
    @(posedge clk_sys) rst <= 1'b1;
    wt(4);
    @(posedge clk_sys) rst <= 1'b0;
    wt(3);
    ask(3'h1, 1'b0, HCE_RSP_PEAK_OFF, 8'h00);
  endtask : t_other
  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wt(3);
    t_query();
    t_faults();
    t_one();
    t_two();
    t_free();
    t_other();
    give_verdict();
  end
endmodule : hce_top_tb_top
